/* File: rtl/wdog_pkg.sv */
// Constants, register map and timing figures of the watchdog and reset-state block.
// Assumes one 250 MHz core clock and a 32-bit Avalon-MM register bus.
// How it works
// R1: Watchdog unclears for 3-4 s: initial reset
// R2: Writing watchdog clear bit clears counter
// R3: Writing zero to watchdog clear does nothing
// R4: Timer clear bit clears timer and watchdog
// R5: Watchdog keeps counting while CPU halted
// R6: Two readable stage bits, zero after reset
// R7: Clear bits and unused bits read zero
// R8: Registers reached directly, no page select
// R9: Software clears watchdog within every 3 s
// R10: Reset loads step 00, page 1, pointer 1
// R11: Reset clears interrupt and decimal flags
// R12: Reset sets display bits of first line
// R13: Initial reset itself clears the watchdog counter

package wdog_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int unsigned CORE_CLK_HZ      = 250_000_000;
	localparam int unsigned TICK_HZ          = 1;
	localparam int unsigned TICK_CYCLES_DFLT = CORE_CLK_HZ / TICK_HZ;
	localparam int unsigned TICK_CNT_W       = 28;
	localparam int unsigned WDOG_MIN_S       = 3;
	localparam int unsigned WDOG_MAX_S       = 4;
	localparam int unsigned WDOG_TICKS       = WDOG_MAX_S * TICK_HZ;
	localparam int unsigned STAGE_W          = 2;
	localparam logic [STAGE_W-1:0] STAGE_LAST = 2'h3;
	localparam logic [STAGE_W-1:0] STAGE_RST  = 2'h0;
	localparam logic [4:0]   HOLD_CYCLES     = 5'h10;

	// ************************************************************
	// Register map (index; byte address is four times it)
	// ************************************************************
	localparam int unsigned  BUS_ADDR_W       = 10;
	localparam int unsigned  IDX_W            = 8;
	localparam logic [7:0]   REG_TMR_CLR_IDX  = 8'he2;
	localparam logic [7:0]   REG_WDOG_IDX     = 8'he5;
	localparam logic [7:0]   REG_IRQ_STAT_IDX = 8'hf0;
	localparam logic [7:0]   REG_IRQ_MASK_IDX = 8'hf1;
	localparam int unsigned  TMR_CLR_BIT      = 0;
	localparam int unsigned  WDOG_CLR_BIT     = 3;
	localparam int unsigned  DATA_W           = 4;

	// Interrupt status layout
	localparam int unsigned  IRQ_W            = 2;
	localparam int unsigned  IRQ_TIMEOUT_BIT  = 0;
	localparam int unsigned  IRQ_PIN_BIT      = 1;

	// ************************************************************
	// Core state loaded by initial reset
	// ************************************************************
	localparam logic [7:0]   PC_STEP_RST      = 8'h00;
	localparam logic [3:0]   PC_PAGE_RST      = 4'h1;
	localparam logic [3:0]   NEXT_PAGE_RST    = 4'h1;
	localparam logic         FLAG_RST         = 1'b0;

	// ************************************************************
	// Display memory
	// ************************************************************
	localparam int unsigned  DISP_WORDS       = 64;
	localparam int unsigned  DISP_ADDR_W      = 6;
	localparam int unsigned  FIRST_LINE_BIT   = 0;

endpackage : wdog_pkg

/* File: rtl/wdog_stage_counter.sv */
// Two-stage watchdog counter advanced by a once-a-second tick.
// Assumes tick and clear come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module wdog_stage_counter
	import wdog_pkg::*;
(
	input  wire logic               clk,     // Core clock
	input  wire logic               rst,     // Synchronous reset
	input  wire logic               clear,   // Restart count
	input  wire logic               tick,    // One-second tick
	output logic [STAGE_W-1:0]      stages,  // Counter stages
	output logic                    timeout  // Pulse at overflow
);
	logic [STAGE_W-1:0] stage_ff;
	logic [STAGE_W-1:0] nxt_stage;

	// Clear wins over tick; no halt input, so halt never stops it
	assign nxt_stage = clear ? STAGE_RST : (tick ? stage_ff + 2'h1 : stage_ff); // [R2] [R5]
	assign timeout   = tick & ~clear & (stage_ff == STAGE_LAST); // [R1]
	assign stages    = stage_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			stage_ff <= STAGE_RST; // [R6]
		end else begin
			stage_ff <= nxt_stage;
		end
	end

	a_stage_clear: assert property (@(posedge clk) disable iff (rst) // [R2]
		clear |=> (stage_ff == STAGE_RST))
		else $error("stages not cleared");

	a_stage_hold: assert property (@(posedge clk) disable iff (rst) // [R3]
		(!clear && !tick) |=> (stage_ff == $past(stage_ff)))
		else $error("stages moved without tick");

endmodule : wdog_stage_counter
`default_nettype wire

/* File: rtl/disp_mem_first_common_line.sv */
// Display memory whose first common line bits are set by initial reset.
// Assumes the CPU writes and reads it on the core clock.
`timescale 1ns/10ps
`default_nettype none
module disp_mem_first_line
	import wdog_pkg::*;
(
	input  wire logic                   clk,      // Core clock
	input  wire logic                   init_rst, // Initial reset level
	input  wire logic                   wr_en,    // Write strobe
	input  wire logic [DISP_ADDR_W-1:0] wr_addr,  // Write word
	input  wire logic [DATA_W-1:0]      wr_data,  // Write data
	input  wire logic [DISP_ADDR_W-1:0] rd_addr,  // Read word
	output logic      [DATA_W-1:0]      rd_data   // Registered read data
);
	logic [DATA_W-1:0] mem [DISP_WORDS];
	logic [DATA_W-1:0] rd_data_ff;

	assign rd_data = rd_data_ff;

	// Only the first line bit is defined; the others keep stale content
	always_ff @(posedge clk) begin
		if (init_rst) begin
			for (int i = 0; i < DISP_WORDS; i++) begin
				mem[i][FIRST_LINE_BIT] <= 1'b1; // [R12]
			end
		end else if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_ff <= mem[rd_addr];
	end

	a_first_line_set: assert property (@(posedge clk) // [R12]
		init_rst ##1 init_rst |=> rd_data_ff[FIRST_LINE_BIT])
		else $error("first line bit not set by reset");

endmodule : disp_mem_first_line
`default_nettype wire

/* File: rtl/wdog_reset_top.sv */
// Watchdog timer with initial reset generation and reset-state of core and display.
// Assumes an Avalon-MM master on CORE_CLK and an active-low reset pin from outside.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module wdog_reset_top
	import wdog_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT // Cycles per second tick
)
(
	input  wire logic                   CORE_CLK,         // Core clock
	input  wire logic                   RST,              // Sync reset, active high
	input  wire logic                   RESET_PIN_N,      // Async reset pin, active low
	input  wire logic [BUS_ADDR_W-1:0]  AVS_ADDRESS,      // Byte address
	input  wire logic                   AVS_READ,         // Read request
	input  wire logic                   AVS_WRITE,        // Write request
	input  wire logic [31:0]            AVS_WRITEDATA,    // Write data
	input  wire logic [3:0]             AVS_BYTEENABLE,   // Byte lanes
	output logic      [31:0]            AVS_READDATA,     // Read data
	output logic                        AVS_WAITREQUEST,  // Stall
	output logic                        IRQ,              // Level interrupt
	output logic                        CPU_RESET,        // Initial reset to CPU
	input  wire logic                   CORE_WR,          // CPU updates core state
	input  wire logic [7:0]             CORE_PC_STEP_IN,  // New step
	input  wire logic [3:0]             CORE_PC_PAGE_IN,  // New page
	input  wire logic [3:0]             CORE_NEXT_PAGE_IN, // New page pointer
	input  wire logic                   CORE_IFLAG_IN,    // New interrupt flag
	input  wire logic                   CORE_DFLAG_IN,    // New decimal flag
	output logic      [7:0]             PC_STEP,          // Program counter step
	output logic      [3:0]             PC_PAGE,          // Program counter page
	output logic      [3:0]             NEXT_PAGE_PTR,    // New page pointer
	output logic                        INT_FLAG,         // Interrupt flag
	output logic                        DEC_FLAG,         // Decimal flag
	input  wire logic                   DISP_WR,          // Display write
	input  wire logic [DISP_ADDR_W-1:0] DISP_WR_ADDR,     // Display write word
	input  wire logic [DATA_W-1:0]      DISP_WR_DATA,     // Display write data
	input  wire logic [DISP_ADDR_W-1:0] DISP_RD_ADDR,     // Display read word
	output logic      [DATA_W-1:0]      DISP_RD_DATA      // Display read data
);

	// ************************************************************
	// Reset pin synchroniser
	// ************************************************************
	logic pin_meta_ff;
	logic pin_sync_ff;
	logic pin_prev_ff;
	logic pin_rst;
	logic pin_rise;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			pin_meta_ff <= 1'b1;
			pin_sync_ff <= 1'b1;
			pin_prev_ff <= 1'b1;
		end else begin
			pin_meta_ff <= RESET_PIN_N;
			pin_sync_ff <= pin_meta_ff;
			pin_prev_ff <= pin_sync_ff;
		end
	end

	assign pin_rst  = ~pin_sync_ff;
	assign pin_rise = ~pin_sync_ff & pin_prev_ff;

	// ************************************************************
	// Avalon-MM slave
	// ************************************************************
	// One wait cycle per access; readdata stands with waitrequest low
	logic                 wait_ff;
	logic [31:0]          rdata_ff;
	logic                 req;
	logic                 acc;
	logic                 wr_acc;
	logic                 rd_acc;
	logic [IDX_W-1:0]     idx;
	logic                 lane0;
	logic                 hit_tmr;
	logic                 hit_wdog;
	logic                 hit_stat;
	logic                 hit_mask;
	logic [DATA_W-1:0]    rd_word;

	assign req      = AVS_READ | AVS_WRITE;
	assign acc      = req & ~wait_ff;
	assign wr_acc   = acc & AVS_WRITE;
	assign rd_acc   = acc & AVS_READ;
	assign idx      = AVS_ADDRESS[BUS_ADDR_W-1:2];
	assign lane0    = AVS_BYTEENABLE[0];
	// Flat decode on the full index, no page register in the path
	assign hit_tmr  = (idx == REG_TMR_CLR_IDX);  // [R8]
	assign hit_wdog = (idx == REG_WDOG_IDX);     // [R8]
	assign hit_stat = (idx == REG_IRQ_STAT_IDX);
	assign hit_mask = (idx == REG_IRQ_MASK_IDX);

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			wait_ff  <= 1'b1;
			rdata_ff <= 32'h0;
		end else begin
			wait_ff  <= ~(req & wait_ff);
			rdata_ff <= {28'h0, rd_word};
		end
	end

	assign AVS_WAITREQUEST = wait_ff;
	assign AVS_READDATA    = rdata_ff;

	// ************************************************************
	// Clock timer prescaler and watchdog
	// ************************************************************
	logic [TICK_CNT_W-1:0] tick_cnt_ff;
	logic [TICK_CNT_W-1:0] nxt_tick_cnt;
	logic                  tick;
	logic                  tmr_clr;
	logic                  wd_clr;
	logic                  wd_zero_wr;
	logic                  cpu_rst_ff;
	logic [STAGE_W-1:0]    stages;
	logic                  timeout;

	assign tick       = (tick_cnt_ff == TICK_CNT_W'(TICK_CYCLES - 1));
	assign tmr_clr    = wr_acc & hit_tmr & lane0 & AVS_WRITEDATA[TMR_CLR_BIT];   // [R4]
	assign wd_zero_wr = wr_acc & hit_wdog & lane0 & ~AVS_WRITEDATA[WDOG_CLR_BIT];
	// A zero in the clear bit is simply not a clear term
	assign wd_clr     = cpu_rst_ff | tmr_clr                                      // [R13] [R4]
		| (wr_acc & hit_wdog & lane0 & AVS_WRITEDATA[WDOG_CLR_BIT]);         // [R2] [R3]
	assign nxt_tick_cnt = (cpu_rst_ff | tmr_clr | tick) ? '0 : tick_cnt_ff + 1'b1; // [R4]

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			tick_cnt_ff <= '0;
		end else begin
			tick_cnt_ff <= nxt_tick_cnt;
		end
	end

	// Ticks are free-running, so timeout lands 3 to 4 s after a clear
	wdog_stage_counter u_stages (
		.clk     (CORE_CLK),
		.rst     (RST),
		.clear   (wd_clr),
		.tick    (tick),
		.stages  (stages),
		.timeout (timeout)
	);

	// ************************************************************
	// Initial reset generation
	// ************************************************************
	logic [4:0] hold_ff;
	logic [4:0] nxt_hold;
	logic       init_req;

	assign init_req = pin_rst | timeout; // [R1] [R5]
	assign nxt_hold = init_req ? HOLD_CYCLES : (hold_ff != 5'h0 ? hold_ff - 5'h1 : hold_ff);

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			hold_ff    <= HOLD_CYCLES;
			cpu_rst_ff <= 1'b1;
		end else begin
			hold_ff    <= nxt_hold;
			cpu_rst_ff <= init_req | (hold_ff != 5'h0); // [R1]
		end
	end

	assign CPU_RESET = cpu_rst_ff;

	// ************************************************************
	// Core state loaded by initial reset
	// ************************************************************
	logic [7:0] pc_step_ff;
	logic [3:0] pc_page_ff;
	logic [3:0] pg_ptr_ff;
	logic       iflag_ff;
	logic       dflag_ff;

	// Other core registers stay undefined and are not held here
	always_ff @(posedge CORE_CLK) begin
		if (cpu_rst_ff) begin
			pc_step_ff <= PC_STEP_RST;   // [R10]
			pc_page_ff <= PC_PAGE_RST;   // [R10]
			pg_ptr_ff  <= NEXT_PAGE_RST; // [R10]
			iflag_ff   <= FLAG_RST;      // [R11]
			dflag_ff   <= FLAG_RST;      // [R11]
		end else if (CORE_WR) begin
			pc_step_ff <= CORE_PC_STEP_IN;
			pc_page_ff <= CORE_PC_PAGE_IN;
			pg_ptr_ff  <= CORE_NEXT_PAGE_IN;
			iflag_ff   <= CORE_IFLAG_IN;
			dflag_ff   <= CORE_DFLAG_IN;
		end
	end

	assign PC_STEP       = pc_step_ff;
	assign PC_PAGE       = pc_page_ff;
	assign NEXT_PAGE_PTR = pg_ptr_ff;
	assign INT_FLAG      = iflag_ff;
	assign DEC_FLAG      = dflag_ff;

	disp_mem_first_line u_disp (
		.clk      (CORE_CLK),
		.init_rst (cpu_rst_ff),
		.wr_en    (DISP_WR & ~cpu_rst_ff),
		.wr_addr  (DISP_WR_ADDR),
		.wr_data  (DISP_WR_DATA),
		.rd_addr  (DISP_RD_ADDR),
		.rd_data  (DISP_RD_DATA)
	);

	// ************************************************************
	// Interrupt status and mask
	// ************************************************************
	logic [IRQ_W-1:0] stat_ff;
	logic [IRQ_W-1:0] mask_ff;
	logic [IRQ_W-1:0] events;
	logic [IRQ_W-1:0] nxt_stat;
	logic [IRQ_W-1:0] nxt_mask;
	logic             irq_ff;

	assign events   = {pin_rise, timeout};
	// A read clears only the bits it handed out, so no event is lost
	assign nxt_stat = (rd_acc & hit_stat ? stat_ff & ~rdata_ff[IRQ_W-1:0] : stat_ff) | events;
	assign nxt_mask = (wr_acc & hit_mask & lane0) ? AVS_WRITEDATA[IRQ_W-1:0] : mask_ff;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			stat_ff <= '0;
			mask_ff <= '0;
			irq_ff  <= 1'b0;
		end else begin
			stat_ff <= nxt_stat;
			mask_ff <= nxt_mask;
			irq_ff  <= |(nxt_stat & nxt_mask);
		end
	end

	assign IRQ = irq_ff;

	// ************************************************************
	// Read data
	// ************************************************************
	// Clear bits and unused bits are never stored, so read as zero
	assign rd_word = hit_wdog ? {2'h0, stages}                 // [R6] [R7]
		: hit_stat ? {{(DATA_W-IRQ_W){1'b0}}, stat_ff}
		: hit_mask ? {{(DATA_W-IRQ_W){1'b0}}, mask_ff}
		: 4'h0;                                                // [R7]

	// ************************************************************
	// Checks
	// ************************************************************
	a_timeout_reset: assert property (@(posedge CORE_CLK) disable iff (RST) // [R1]
		(tick && stages == STAGE_LAST && !wd_clr) |=> CPU_RESET [*8])
		else $error("timeout did not raise initial reset");

	a_wdclr_write: assert property (@(posedge CORE_CLK) disable iff (RST) // [R2]
		(wr_acc && hit_wdog && lane0 && AVS_WRITEDATA[WDOG_CLR_BIT]) |=> stages == STAGE_RST)
		else $error("watchdog clear write ignored");

	a_zero_write: assert property (@(posedge CORE_CLK) disable iff (RST) // [R3]
		(wd_zero_wr && !tick && !cpu_rst_ff && !tmr_clr) |=> stages == $past(stages))
		else $error("zero write disturbed the counter");

	a_tmrclr_both: assert property (@(posedge CORE_CLK) disable iff (RST) // [R4]
		tmr_clr |=> (stages == STAGE_RST && tick_cnt_ff == '0))
		else $error("timer clear missed watchdog");

	a_reset_clears: assert property (@(posedge CORE_CLK) disable iff (RST) // [R13]
		$fell(CPU_RESET) |-> (stages == STAGE_RST && tick_cnt_ff == '0))
		else $error("reset release with stale counter");

	a_stage_read: assert property (@(posedge CORE_CLK) disable iff (RST) // [R7]
		(rd_acc && (hit_tmr || hit_wdog)) |-> AVS_READDATA[31:2] == 30'h0)
		else $error("write-only or unused bits read as one");

	a_core_load: assert property (@(posedge CORE_CLK) disable iff (RST) // [R10]
		CPU_RESET |=> (PC_STEP == PC_STEP_RST && PC_PAGE == PC_PAGE_RST
			&& NEXT_PAGE_PTR == NEXT_PAGE_RST))
		else $error("core not loaded by initial reset");

	a_flag_clear: assert property (@(posedge CORE_CLK) disable iff (RST) // [R11]
		CPU_RESET |=> (!INT_FLAG && !DEC_FLAG))
		else $error("flags not cleared by initial reset");

	a_one_wait: assert property (@(posedge CORE_CLK) disable iff (RST)
		(req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
		else $error("bus answer not after one wait cycle");

	// ************************************************************
	// Interrupt, bus, counter and reset checks
	// ************************************************************
	a_irq_level: assert property (@(posedge CORE_CLK) disable iff (RST)
		IRQ == |(stat_ff & mask_ff))
		else $error("interrupt level disagrees with status and mask");

	a_timeout_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
		timeout |=> stat_ff[IRQ_TIMEOUT_BIT])
		else $error("timeout not recorded in status");

	a_pin_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
		pin_rise |=> stat_ff[IRQ_PIN_BIT])
		else $error("pin reset not recorded in status");

	a_stat_sticky: assert property (@(posedge CORE_CLK) disable iff (RST)
		!(rd_acc && hit_stat) |=> (stat_ff & $past(stat_ff)) == $past(stat_ff))
		else $error("status bit dropped without a read");

	// A read that handed out every set bit, with no new event, leaves status empty
	a_stat_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
		(rd_acc && hit_stat && events == '0 && rdata_ff[IRQ_W-1:0] == stat_ff)
		|=> stat_ff == '0)
		else $error("status not cleared by its read");

	a_tmr_read_zero: assert property (@(posedge CORE_CLK) disable iff (RST) // [R7]
		(rd_acc && hit_tmr) |-> AVS_READDATA == 32'h0)
		else $error("timer clear register read not zero");

	a_rdata_upper: assert property (@(posedge CORE_CLK) disable iff (RST) // [R7]
		AVS_READDATA[31:DATA_W] == '0)
		else $error("read data above the register width not zero");

	a_reset_holds: assert property (@(posedge CORE_CLK) disable iff (RST) // [R13]
		CPU_RESET |=> (stages == STAGE_RST && tick_cnt_ff == '0))
		else $error("watchdog counted during initial reset");

	a_stage_step: assert property (@(posedge CORE_CLK) disable iff (RST) // [R5]
		(tick && !wd_clr) |=> stages == $past(stages) + 2'h1)
		else $error("stage counter missed a tick");

	a_hold_length: assert property (@(posedge CORE_CLK) disable iff (RST) // [R1]
		$rose(CPU_RESET) |-> CPU_RESET [*8] ##1 CPU_RESET [*8])
		else $error("initial reset shorter than its hold");

	a_wait_idle: assert property (@(posedge CORE_CLK) disable iff (RST)
		!req |=> AVS_WAITREQUEST)
		else $error("waitrequest low without a request");

	a_pin_reset: assert property (@(posedge CORE_CLK) disable iff (RST)
		pin_rst |=> CPU_RESET)
		else $error("reset pin did not raise initial reset");

	a_mask_lane: assert property (@(posedge CORE_CLK) disable iff (RST)
		(wr_acc && hit_mask && !lane0) |=> mask_ff == $past(mask_ff))
		else $error("mask written without lane zero");

endmodule : wdog_reset_top
`default_nettype wire

/* File: testbench/cpu_model.sv */
// Behavioural CPU core on the far side of the block: loads its own state and fills the display.
// Assumes CPU_RESET from the block stops it and that run gates its state and display writes.
`timescale 1ns/10ps
`default_nettype none
module cpu_model
	import wdog_pkg::*;
(
	input  wire logic                   clk,      // Core clock
	input  wire logic                   cpu_reset, // Initial reset from block
	input  wire logic                   run,      // Activity enable
	output logic                        core_wr,  // State load
	output logic      [7:0]             step,     // Step value
	output logic      [3:0]             page,     // Page value
	output logic      [3:0]             next_page, // Page pointer value
	output logic                        iflag,    // Interrupt flag value
	output logic                        dflag,    // Decimal flag value
	output logic                        disp_wr,  // Display write
	output logic      [DISP_ADDR_W-1:0] disp_addr, // Display word
	output logic      [DATA_W-1:0]      disp_data // Display data
);
	// Values differ from the reset values so that a reset shows
	assign step = 8'h5a;
	assign page = 4'h7;
	assign next_page = 4'h9;
	assign iflag = 1'b1;
	assign dflag = 1'b1;
	// Bit 0 written clear so the first-line set is visible
	assign disp_data = 4'he;
	initial begin
		core_wr = 1'b0;
		disp_wr = 1'b0;
		disp_addr = '0;
	end
	always @(posedge clk) begin
		core_wr <= run && !cpu_reset;
		disp_wr <= run && !cpu_reset;
		disp_addr <= disp_addr + 1'b1;
	end
endmodule : cpu_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the watchdog and reset-state block.
// Assumes a short tick parameter so a timeout spans a few dozen cycles.
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import wdog_pkg::*;
;
	localparam int unsigned TCK = 20;
	localparam int LO = 3 * TCK;
	localparam int HI = 4 * TCK + 4;
	logic CORE_CLK = 1'b0, RST = 1'b1, RESET_PIN_N = 1'b1, run = 1'b0;
	logic AVS_READ = 1'b0, AVS_WRITE = 1'b0;
	logic [BUS_ADDR_W-1:0] AVS_ADDRESS = '0;
	logic [31:0] AVS_WRITEDATA = '0, AVS_READDATA, rdv;
	logic [3:0] AVS_BYTEENABLE = 4'hf;
	logic AVS_WAITREQUEST, IRQ, CPU_RESET, CORE_WR, CORE_IFLAG_IN, CORE_DFLAG_IN;
	logic [7:0] CORE_PC_STEP_IN, PC_STEP;
	logic [3:0] CORE_PC_PAGE_IN, CORE_NEXT_PAGE_IN, PC_PAGE, NEXT_PAGE_PTR;
	logic INT_FLAG, DEC_FLAG, DISP_WR;
	logic [DISP_ADDR_W-1:0] DISP_WR_ADDR, DISP_RD_ADDR = 6'h05;
	logic [DATA_W-1:0] DISP_WR_DATA, DISP_RD_DATA;
	int miscompares = 0, checks = 0, cyc = 0, t0;

	wdog_reset_top #(.TICK_CYCLES(TCK)) wdog_reset_top_inst (.CORE_CLK, .RST, .RESET_PIN_N,
		.AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
		.AVS_WAITREQUEST, .IRQ, .CPU_RESET, .CORE_WR, .CORE_PC_STEP_IN, .CORE_PC_PAGE_IN,
		.CORE_NEXT_PAGE_IN, .CORE_IFLAG_IN, .CORE_DFLAG_IN, .PC_STEP, .PC_PAGE, .NEXT_PAGE_PTR,
		.INT_FLAG, .DEC_FLAG, .DISP_WR, .DISP_WR_ADDR, .DISP_WR_DATA, .DISP_RD_ADDR,
		.DISP_RD_DATA);
	cpu_model cpu_model_inst (.clk(CORE_CLK), .cpu_reset(CPU_RESET), .run(run),
		.core_wr(CORE_WR), .step(CORE_PC_STEP_IN), .page(CORE_PC_PAGE_IN),
		.next_page(CORE_NEXT_PAGE_IN), .iflag(CORE_IFLAG_IN), .dflag(CORE_DFLAG_IN),
		.disp_wr(DISP_WR), .disp_addr(DISP_WR_ADDR), .disp_data(DISP_WR_DATA));

	always #2 CORE_CLK = ~CORE_CLK;
	always @(posedge CORE_CLK) cyc <= cyc + 1;

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// One Avalon access; an edge passes first so a request never follows a release at once
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [3:0] d);
		@(posedge CORE_CLK);
		AVS_ADDRESS <= {idx, 2'b00};
		AVS_WRITEDATA <= {28'h0, d};
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		// No own limit: a stuck slave is caught by the run watchdog
		do begin
			@(posedge CORE_CLK);
		end while (AVS_WAITREQUEST !== 1'b0);
		rdv = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
	endtask : bus
	task automatic wait_rst(input logic lvl);
		while (CPU_RESET !== lvl) begin
			@(posedge CORE_CLK);
		end
	endtask : wait_rst
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_regs;
		bus(1'b0, REG_WDOG_IDX, 4'h0); check(rdv, 32'h0);
		bus(1'b0, REG_TMR_CLR_IDX, 4'h0); check(rdv, 32'h0);
		bus(1'b1, 8'h10, 4'hf);
		bus(1'b0, 8'h10, 4'h0); check(rdv, 32'h0);
		bus(1'b1, REG_IRQ_MASK_IDX, 4'h3);
		bus(1'b0, REG_IRQ_MASK_IDX, 4'h0); check(rdv, 32'h3);
		// Write without lane zero must be refused
		AVS_BYTEENABLE <= 4'he;
		bus(1'b1, REG_IRQ_MASK_IDX, 4'h0);
		AVS_BYTEENABLE <= 4'hf;
		bus(1'b0, REG_IRQ_MASK_IDX, 4'h0); check(rdv, 32'h3);
		bus(1'b1, REG_IRQ_MASK_IDX, 4'h0);
		bus(1'b0, REG_IRQ_STAT_IDX, 4'h0);
	endtask : t_regs
	task automatic t_timer_clear;
		run <= 1'b1;
		bus(1'b1, REG_TMR_CLR_IDX, 4'h1);
		t0 = cyc;
		bus(1'b1, REG_WDOG_IDX, 4'h0);
		bus(1'b1, REG_TMR_CLR_IDX, 4'h0);
		while (cyc - t0 < 50) @(posedge CORE_CLK);
		// Two ticks have passed, so the quarter-Hz stage alone is up
		bus(1'b0, REG_WDOG_IDX, 4'h0); check(rdv, 32'h2);
		check(PC_STEP, 8'h5a);
		check(DISP_RD_DATA, 4'he);
		wait_rst(1'b1);
		check(32'(cyc - t0 >= LO && cyc - t0 <= HI), 32'h1);
	endtask : t_timer_clear
	task automatic t_reset_values;
		repeat (3) @(posedge CORE_CLK);
		check(PC_STEP, PC_STEP_RST);
		check(PC_PAGE, PC_PAGE_RST);
		check(NEXT_PAGE_PTR, NEXT_PAGE_RST);
		check(INT_FLAG, FLAG_RST);
		check(DEC_FLAG, FLAG_RST);
		check(DISP_RD_DATA[FIRST_LINE_BIT], 1'b1);
	endtask : t_reset_values
	task automatic t_restart;
		wait_rst(1'b0);
		t0 = cyc;
		wait_rst(1'b1);
		check(32'(cyc - t0 >= LO && cyc - t0 <= HI), 32'h1);
		wait_rst(1'b0);
	endtask : t_restart
	task automatic t_irq;
		bus(1'b1, REG_TMR_CLR_IDX, 4'h1);
		check(IRQ, 1'b0);
		bus(1'b1, REG_IRQ_MASK_IDX, 4'h1);
		repeat (3) @(posedge CORE_CLK);
		check(IRQ, 1'b1);
		bus(1'b0, REG_IRQ_STAT_IDX, 4'h0); check(rdv, 32'h1);
		repeat (3) @(posedge CORE_CLK);
		check(IRQ, 1'b0);
	endtask : t_irq
	task automatic t_keepalive;
		logic saw;
		saw = 1'b0;
		// Clears every two ticks, well inside the three-tick minimum
		for (int i = 0; i < 6; i++) begin
			repeat (40) begin
				@(posedge CORE_CLK);
				if (CPU_RESET !== 1'b0) saw = 1'b1;
			end
			if (i[0]) bus(1'b1, REG_TMR_CLR_IDX, 4'h1);
			else bus(1'b1, REG_WDOG_IDX, 4'h8);
		end
		check(saw, 1'b0);
	endtask : t_keepalive
	task automatic t_pin;
		bus(1'b1, REG_IRQ_MASK_IDX, 4'h2);
		RESET_PIN_N <= 1'b0;
		repeat (6) @(posedge CORE_CLK);
		check(CPU_RESET, 1'b1);
		RESET_PIN_N <= 1'b1;
		wait_rst(1'b0);
		check(IRQ, 1'b1);
		bus(1'b0, REG_IRQ_STAT_IDX, 4'h0); check(rdv, 32'h2);
		repeat (3) @(posedge CORE_CLK);
		check(IRQ, 1'b0);
	endtask : t_pin

	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	initial begin
		repeat (5) @(posedge CORE_CLK);
		RST <= 1'b0;
		wait_rst(1'b0);
		t_regs;
		t_timer_clear;
		t_reset_values;
		t_restart;
		t_irq;
		t_keepalive;
		t_pin;
		wrap_up;
	end
	// Whole run is well under 2000 cycles
	initial begin
		#20000;
		miscompares++;
		wrap_up;
	end
endmodule : tb_top
`default_nettype wire
